//--- fbas_pkg.sv
// Constants, state encodings and shared types for the fieldbus fault and sync command block
//
// Overview of operation
// - Fault read is code 05h, echoed; selector bytes 4-5, pointer 6-7, list 8-31.
// - Each fault or warning in the list occupies one two-byte code.
// - History is listed by occurrence, newest entry first.
// - With nothing present the fault list reads all zeros.
// - The entry pointer written by the master is only echoed; it has no effect on the list.
// - Read selector picks present fault state or fault history.
// - Read is done when code 05h echoes, ready is 1, selector and pointer echo.
// - An invalid read selector gives command alarm code 9.
// - Fault clear is code 06h, echoed; selector bytes 4-5; bytes 6-31 reserved.
// - Clear selector 0 clears present state, 1 erases the history.
// - An invalid clear selector gives command alarm code 9.
// - Clear is done when code 06h echoes, ready is 1, selector echoes.
// - Clearing resets fault state only; the underlying cause is untouched.
// - Sync start is code 0Dh, echoed; bytes 4-31 reserved both ways.
// - Finishing sync start puts the device into synchronous mode, also when recovering.
// - Sync start locks by following the master watchdog count from frame to frame.
// - Watchdog error checking is enabled only after sync start completes.
// - Sync start is done on echoed 0Dh with ready 1; it never raises alarms.
// - Ready flag is 0 while a command executes, 1 before and after.
package fbas_pkg;
  localparam int FBAS_LIST_ENTRIES = 12;
  localparam int FBAS_CODE_W = 16;
  localparam logic [7:0] FBAS_CMD_FAULT_READ = 8'h05;
  localparam logic [7:0] FBAS_CMD_FAULT_CLEAR = 8'h06;
  localparam logic [7:0] FBAS_CMD_SYNC_START = 8'h0d;
  localparam int FBAS_BYTE_CODE = 0;
  localparam int FBAS_BYTE_WD = 1;
  localparam int FBAS_BYTE_STAT = 2;
  localparam int FBAS_BYTE_SEL = 4;
  localparam int FBAS_BYTE_PTR = 6;
  localparam int FBAS_BYTE_LIST = 8;
  localparam int FBAS_STAT_ALARM_LSB = 8;
  localparam int FBAS_STAT_READY_BIT = 15;
  localparam logic [3:0] FBAS_ALARM_NONE = 4'h0;
  localparam logic [3:0] FBAS_ALARM_BAD_PARAM = 4'h9;
  localparam logic [15:0] FBAS_SEL_PRESENT = 16'h0000;
  localparam logic [15:0] FBAS_SEL_HISTORY = 16'h0001;
  localparam logic [15:0] FBAS_WD_FAULT_CODE = 16'h0001;
  localparam int FBAS_EXEC_TIME_NS = 40;
  localparam int FBAS_CLK_PERIOD_NS = 4;
  localparam int FBAS_EXEC_CYCLES = (FBAS_EXEC_TIME_NS + FBAS_CLK_PERIOD_NS - 1) / FBAS_CLK_PERIOD_NS;
  localparam int FBAS_SYNC_FRAMES = 4;
  localparam logic [7:0] FBAS_REG_CTRL = 8'h00;
  localparam logic [7:0] FBAS_REG_STATUS = 8'h04;
  localparam logic [7:0] FBAS_RST_BYTE = 8'h00;
  typedef enum logic [2:0] {
    FBAS_ST_IDLE = 3'b001,
    FBAS_ST_EXEC = 3'b010,
    FBAS_ST_SYNC = 3'b100
  } fbas_state_t;
  typedef enum logic [2:0] {
    FBAS_WD_OFF = 3'b001,
    FBAS_WD_HUNT = 3'b010,
    FBAS_WD_CHECK = 3'b100
  } fbas_wd_state_t;
  typedef logic [FBAS_LIST_ENTRIES-1:0][FBAS_CODE_W-1:0] fbas_list_t;
endpackage

//--- fbas_if.sv
// Interfaces joining the command core to its fault store and watchdog tracker
`timescale 1ns/1ns
`default_nettype none
interface fbas_flt_if import fbas_pkg::*;;
  logic push;
  logic [FBAS_CODE_W-1:0] code;
  logic clr_present;
  logic clr_hist;
  fbas_list_t present_list;
  fbas_list_t hist_list;
  modport store(input push, code, clr_present, clr_hist, output present_list, hist_list);
  modport ctrl(output push, code, clr_present, clr_hist, input present_list, hist_list);
endinterface
interface fbas_wd_if;
  logic frame;
  logic hunt;
  logic [7:0] wd_count;
  logic done;
  logic err;
  logic checking;
  modport track(input frame, hunt, wd_count, output done, err, checking);
  modport ctrl(output frame, hunt, wd_count, input done, err, checking);
endinterface
`default_nettype wire

//--- fbas_fault_store.sv
// Present fault list and fault history, newest entry at index zero
`timescale 1ns/1ns
`default_nettype none
module fbas_fault_store import fbas_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  fbas_flt_if.store flt
);
  typedef struct packed {
    fbas_list_t present;
    fbas_list_t hist;
  } fbas_store_t;
  fbas_store_t s_reg;
  fbas_store_t s_next;
  // Clear first, then insert: a fault arriving with the clear survives it
  always_comb begin
    s_next = s_reg;
    if (flt.clr_present) begin
      s_next.present = '0;
    end
    if (flt.clr_hist) begin
      s_next.hist = '0;
    end
    if (flt.push) begin
      // Shift in at entry 0, oldest of twelve drops out
      s_next.present = {s_next.present[FBAS_LIST_ENTRIES-2:0], flt.code};
      s_next.hist = {s_next.hist[FBAS_LIST_ENTRIES-2:0], flt.code};
    end
  end
  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  assign flt.present_list = s_reg.present;
  assign flt.hist_list = s_reg.hist;
endmodule // fbas_fault_store
`default_nettype wire

//--- fbas_wd_track.sv
// Follows the master watchdog count: locks during sync start, then checks each frame
`timescale 1ns/1ns
`default_nettype none
module fbas_wd_track import fbas_pkg::*; #(
  parameter int SYNC_FRAMES = FBAS_SYNC_FRAMES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  fbas_wd_if.track wd
);
  typedef struct packed {
    fbas_wd_state_t mode;
    logic [7:0] prev;
    logic [3:0] cnt;
  } fbas_wd_reg_t;
  fbas_wd_reg_t s_reg;
  fbas_wd_reg_t s_next;
  logic step_ok;
  // A good step is exactly one count up, wrapping at 255
  always_comb begin
    s_next = s_reg;
    step_ok = (wd.wd_count == s_reg.prev + 8'h01);
    wd.done = 1'b0;
    wd.err = 1'b0;
    if (wd.frame) begin
      s_next.prev = wd.wd_count;
    end
    case (s_reg.mode)
      FBAS_WD_OFF: begin
        if (wd.hunt) begin
          s_next.mode = FBAS_WD_HUNT;
          s_next.cnt = 4'h0;
        end
      end
      FBAS_WD_HUNT: begin
        if (wd.frame && step_ok) begin
          s_next.cnt = s_reg.cnt + 4'h1;
          if (s_reg.cnt == 4'(SYNC_FRAMES - 1)) begin
            wd.done = 1'b1;
            s_next.mode = FBAS_WD_CHECK;
          end
        end else if (wd.frame) begin
          s_next.cnt = 4'h0; // Broken sequence restarts the lock
        end
      end
      FBAS_WD_CHECK: begin
        if (wd.frame && !step_ok) begin
          wd.err = 1'b1;
          s_next.mode = FBAS_WD_OFF;
        end
      end
      default: begin
        s_next.mode = FBAS_WD_OFF;
      end
    endcase
  end
  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{mode: FBAS_WD_OFF, prev: FBAS_RST_BYTE, cnt: 4'h0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  assign wd.checking = (s_reg.mode == FBAS_WD_CHECK);
endmodule // fbas_wd_track
`default_nettype wire

//--- fbas_cmd_core.sv
// Command interpreter for fault read, fault clear and sync start, with a Wishbone slave
`timescale 1ns/1ns
`default_nettype none
module fbas_cmd_core import fbas_pkg::*; #(
  parameter int EXEC_CYCLES = FBAS_EXEC_CYCLES,
  parameter int SYNC_FRAMES = FBAS_SYNC_FRAMES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmd_frame_valid,
  input wire logic [255:0] cmd_frame,
  output logic [255:0] rsp_frame,
  output logic rsp_frame_valid,
  output logic sync_mode,
  output logic wd_check_on
);
  ////////////////////////////////////////////////////////////////////////////
  // Frame field helpers
  function automatic logic [7:0] fbas_byte(input logic [255:0] f, input int idx);
    fbas_byte = f[8*idx +: 8];
  endfunction

  function automatic logic [15:0] fbas_half(input logic [255:0] f, input int idx);
    fbas_half = f[8*idx +: 16]; // Low byte first on the wire
  endfunction

  // Selector legal for both read and clear: 0 present, 1 history
  function automatic logic fbas_sel_ok(input logic [15:0] sel);
    fbas_sel_ok = (sel == FBAS_SEL_PRESENT) || (sel == FBAS_SEL_HISTORY);
  endfunction

  // Builds a whole response; everything not named stays zero
  function automatic logic [255:0] fbas_rsp(
    input logic [7:0] code,
    input logic [7:0] swd,
    input logic ready,
    input logic [3:0] alarm,
    input logic [15:0] sel,
    input logic [15:0] ptr,
    input fbas_list_t list
  );
    logic [255:0] r;
    logic [15:0] stat;
    r = '0;
    stat = '0;
    stat[FBAS_STAT_READY_BIT] = ready;
    stat[FBAS_STAT_ALARM_LSB +: 4] = alarm;
    r[8*FBAS_BYTE_CODE +: 8] = code;
    r[8*FBAS_BYTE_WD +: 8] = swd;
    r[8*FBAS_BYTE_STAT +: 16] = stat;
    if (code == FBAS_CMD_FAULT_READ) begin
      r[8*FBAS_BYTE_SEL +: 16] = sel;
      r[8*FBAS_BYTE_PTR +: 16] = ptr;
      r[8*FBAS_BYTE_LIST +: 192] = list;
    end else if (code == FBAS_CMD_FAULT_CLEAR) begin
      r[8*FBAS_BYTE_SEL +: 16] = sel;
    end
    fbas_rsp = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    fbas_state_t st;
    logic [7:0] exec_cnt;
    logic [7:0] cmd_code;
    logic [15:0] cmd_sel;
    logic [15:0] cmd_ptr;
    logic done_valid;
    logic [7:0] done_code;
    logic [15:0] done_sel;
    logic [3:0] alarm;
    logic [7:0] slave_wd;
    logic sync_on;
    logic [255:0] rsp;
    logic rsp_vld;
    logic inj_pend;
    logic [15:0] inj_code;
    logic wb_ack;
    logic [31:0] wb_dat;
  } fbas_core_t;

  fbas_core_t s_reg;
  fbas_core_t s_next;

  fbas_flt_if flt();
  fbas_wd_if wd();

  logic [7:0] f_code;
  logic [15:0] f_sel;
  logic [15:0] f_ptr;
  logic bus_go;
  logic same_cmd;
  logic ready;
  fbas_list_t rsp_list;

  ////////////////////////////////////////////////////////////////////////////
  // Leaf blocks
  fbas_fault_store u_store (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .flt(flt.store)
  );

  fbas_wd_track #(
    .SYNC_FRAMES(SYNC_FRAMES)
  ) u_wd (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .wd(wd.track)
  );

  // Incoming frame fields, same clock as the link logic so no synchroniser
  assign f_code = fbas_byte(cmd_frame, FBAS_BYTE_CODE);
  assign f_sel = fbas_half(cmd_frame, FBAS_BYTE_SEL);
  assign f_ptr = fbas_half(cmd_frame, FBAS_BYTE_PTR); // Echoed only, never acted on
  assign same_cmd = s_reg.done_valid && (f_code == s_reg.done_code) && (f_sel == s_reg.done_sel);
  assign bus_go = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;

  assign wd.frame = cmd_frame_valid;
  assign wd.wd_count = fbas_byte(cmd_frame, FBAS_BYTE_WD);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.rsp_vld = 1'b0;
    s_next.wb_ack = 1'b0;
    flt.push = 1'b0;
    flt.code = '0;
    flt.clr_present = 1'b0;
    flt.clr_hist = 1'b0;
    wd.hunt = 1'b0;
    ready = 1'b1;
    rsp_list = '0;

    // One fault push per cycle; a watchdog error outranks a software injection
    if (wd.err) begin
      flt.push = 1'b1;
      flt.code = FBAS_WD_FAULT_CODE;
      s_next.sync_on = 1'b0; // Falls back to asynchronous until sync start again
    end else if (s_reg.inj_pend) begin
      flt.push = 1'b1;
      flt.code = s_reg.inj_code;
      s_next.inj_pend = 1'b0;
    end

    // Command sequencer
    case (s_reg.st)
      FBAS_ST_IDLE: begin
        if (cmd_frame_valid) begin
          s_next.cmd_code = f_code;
          s_next.cmd_sel = f_sel;
          s_next.cmd_ptr = f_ptr;
          if ((f_code == FBAS_CMD_FAULT_READ || f_code == FBAS_CMD_FAULT_CLEAR) && !same_cmd) begin
            s_next.st = FBAS_ST_EXEC;
            s_next.exec_cnt = 8'(EXEC_CYCLES - 1);
            s_next.alarm = FBAS_ALARM_NONE;
          end else if (f_code == FBAS_CMD_SYNC_START && !s_reg.sync_on) begin
            s_next.st = FBAS_ST_SYNC;
            s_next.alarm = FBAS_ALARM_NONE;
            wd.hunt = 1'b1;
          end else if (f_code == FBAS_CMD_SYNC_START) begin
            s_next.alarm = FBAS_ALARM_NONE; // Already synchronous, reports done at once
          end
        end
      end
      FBAS_ST_EXEC: begin
        if (s_reg.exec_cnt != 8'h00) begin
          s_next.exec_cnt = s_reg.exec_cnt - 8'h01;
        end else begin
          s_next.st = FBAS_ST_IDLE;
          s_next.done_valid = 1'b1;
          s_next.done_code = s_reg.cmd_code;
          s_next.done_sel = s_reg.cmd_sel;
          if (!fbas_sel_ok(s_reg.cmd_sel)) begin
            s_next.alarm = FBAS_ALARM_BAD_PARAM;
          end else if (s_reg.cmd_code == FBAS_CMD_FAULT_CLEAR) begin
            // Only the recorded state goes; sync mode and live causes stay
            flt.clr_present = (s_reg.cmd_sel == FBAS_SEL_PRESENT);
            flt.clr_hist = (s_reg.cmd_sel == FBAS_SEL_HISTORY);
          end
        end
      end
      FBAS_ST_SYNC: begin
        // Master keeps repeating the command while we hunt
        if (wd.done) begin
          s_next.st = FBAS_ST_IDLE;
          s_next.sync_on = 1'b1;
          s_next.done_valid = 1'b0;
        end
      end
      default: begin
        s_next.st = FBAS_ST_IDLE;
      end
    endcase

    // Answer every command frame; a frame that meets the last execution cycle still reads busy,
    // so it never carries a stale echo or a list from before the clear
    ready = (s_next.st == FBAS_ST_IDLE) && (s_reg.st != FBAS_ST_EXEC);
    if (s_next.cmd_code == FBAS_CMD_FAULT_READ && ready && s_next.alarm == FBAS_ALARM_NONE) begin
      // Selector picks the list; anything else leaves zeros
      if (s_next.cmd_sel == FBAS_SEL_HISTORY) begin
        rsp_list = flt.hist_list;
      end else if (s_next.cmd_sel == FBAS_SEL_PRESENT) begin
        rsp_list = flt.present_list;
      end
    end
    if (cmd_frame_valid) begin
      s_next.slave_wd = s_reg.slave_wd + 8'h01;
      s_next.rsp = fbas_rsp(s_next.cmd_code, s_reg.slave_wd, ready,
                            ready ? s_next.alarm : FBAS_ALARM_NONE,
                            s_next.cmd_sel, s_next.cmd_ptr, rsp_list);
      s_next.rsp_vld = 1'b1;
    end

    // Wishbone slave: single-cycle ack, unmapped reads give zero, writes there are dropped
    if (bus_go) begin
      s_next.wb_ack = 1'b1;
      s_next.wb_dat = '0;
      case (wb_adr_i)
        FBAS_REG_CTRL: begin
          s_next.wb_dat = {s_reg.inj_code, 15'h0000, s_reg.inj_pend};
          if (wb_we_i) begin
            if (wb_sel_i[2]) begin
              s_next.inj_code[7:0] = wb_dat_i[23:16];
            end
            if (wb_sel_i[3]) begin
              s_next.inj_code[15:8] = wb_dat_i[31:24];
            end
            // Set wins over the grant in the same cycle
            if (wb_sel_i[0] && wb_dat_i[0]) begin
              s_next.inj_pend = 1'b1;
            end
          end
        end
        FBAS_REG_STATUS: begin
          s_next.wb_dat = {8'h00, s_reg.cmd_code, 4'h0, s_reg.alarm,
                           3'b000, s_reg.st, wd.checking, s_reg.sync_on};
        end
        default: begin
          s_next.wb_dat = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; ce low freezes everything
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.st <= FBAS_ST_IDLE;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops, apart from the tracker's checking flag
  assign rsp_frame = s_reg.rsp;
  assign rsp_frame_valid = s_reg.rsp_vld;
  assign wb_dat_o = s_reg.wb_dat;
  assign wb_ack_o = s_reg.wb_ack;
  assign sync_mode = s_reg.sync_on;
  assign wd_check_on = wd.checking;
endmodule // fbas_cmd_core
`default_nettype wire

//--- fbas_cmd_core_checker.sv
// Port assertions for the fieldbus fault and sync command block
`timescale 1ns/1ns
`default_nettype none
module fbas_cmd_core_checker import fbas_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cmd_frame_valid,
  input wire logic [255:0] cmd_frame,
  input wire logic [255:0] rsp_frame,
  input wire logic rsp_frame_valid,
  input wire logic sync_mode,
  input wire logic wd_check_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // A response that reports its command finished, ready bit is frame bit 31
  sequence s_done(logic [7:0] c);
    rsp_frame_valid && rsp_frame[31] && rsp_frame[7:0] == c;
  endsequence
  // A response still busy with a command
  sequence s_busy(logic [7:0] c);
    rsp_frame_valid && !rsp_frame[31] && rsp_frame[7:0] == c;
  endsequence
  chk_rsp_follows: assert property (ce && cmd_frame_valid |=> rsp_frame_valid)
    else $error("response missing after a frame");
  chk_rsp_no_extra: assert property (ce && !cmd_frame_valid |=> !rsp_frame_valid)
    else $error("response without a frame");
  chk_echo_done: assert property (rsp_frame_valid && rsp_frame[31] |-> rsp_frame[7:0] == $past(cmd_frame[7:0]))
    else $error("finished response does not echo the code");
  chk_read_echo: assert property (s_done(FBAS_CMD_FAULT_READ) |-> rsp_frame[63:32] == $past(cmd_frame[63:32]))
    else $error("read selector or pointer not echoed");
  chk_read_bad_sel: assert property (s_done(FBAS_CMD_FAULT_READ) ##0 rsp_frame[47:32] > 16'h0001
    |-> rsp_frame[27:24] == FBAS_ALARM_BAD_PARAM && rsp_frame[255:64] == '0)
    else $error("bad read selector without alarm");
  chk_clear_bad_sel: assert property (s_done(FBAS_CMD_FAULT_CLEAR) ##0 rsp_frame[47:32] > 16'h0001
    |-> rsp_frame[27:24] == FBAS_ALARM_BAD_PARAM)
    else $error("bad clear selector without alarm");
  chk_clear_reserved: assert property (s_done(FBAS_CMD_FAULT_CLEAR) |-> rsp_frame[255:48] == '0)
    else $error("clear response reserved bytes not zero");
  chk_sync_reserved: assert property (s_done(FBAS_CMD_SYNC_START) or s_busy(FBAS_CMD_SYNC_START)
    |-> rsp_frame[255:32] == '0)
    else $error("sync response reserved bytes not zero");
  chk_sync_no_alarm: assert property (s_done(FBAS_CMD_SYNC_START) |-> rsp_frame[27:24] == FBAS_ALARM_NONE)
    else $error("sync start raised an alarm");
  chk_sync_entered: assert property (s_done(FBAS_CMD_SYNC_START) |-> ##[0:1] sync_mode)
    else $error("sync mode not entered");
  chk_sync_unchecked: assert property (s_busy(FBAS_CMD_SYNC_START) |-> !wd_check_on)
    else $error("watchdog check on before sync done");
  chk_wb_answer: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single pulse");
endmodule // fbas_cmd_core_checker
bind fbas_cmd_core fbas_cmd_core_checker fbas_cmd_core_checker_i (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cmd_frame_valid(cmd_frame_valid),
  .cmd_frame(cmd_frame), .rsp_frame(rsp_frame), .rsp_frame_valid(rsp_frame_valid), .sync_mode(sync_mode),
  .wd_check_on(wd_check_on));
`default_nettype wire

//--- fbas_master_model.sv
// Behavioural fieldbus master that builds command frames
`timescale 1ns/1ns
`default_nettype none
module fbas_master_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic send,
  input wire logic skip_wd,
  input wire logic [7:0] code,
  input wire logic [15:0] sel,
  input wire logic [15:0] ptr,
  input wire logic [191:0] fill,
  output logic cmd_frame_valid,
  output logic [255:0] cmd_frame
);
  logic [7:0] wd_reg;
  logic [7:0] wd_next;
  ////////////////////////////////////////
  // Count steps by one per frame, by two only when a break is ordered
  assign wd_next = wd_reg + (skip_wd ? 8'h02 : 8'h01);
  // One frame per send; idle lines toggle so a stale frame never looks current
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_reg <= 8'h00;
      cmd_frame_valid <= 1'b0;
      cmd_frame <= '0;
    end else if (send) begin
      wd_reg <= wd_next;
      cmd_frame_valid <= 1'b1;
      cmd_frame <= {fill, ptr, sel, 16'h0000, wd_next, code}; // Reserved bytes carry noise
    end else begin
      cmd_frame_valid <= 1'b0;
      cmd_frame <= ~cmd_frame;
    end
  end
endmodule // fbas_master_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the fieldbus fault and sync command block
`timescale 1ns/1ns
`default_nettype none
module tb_top import fbas_pkg::*;;
  localparam int EXEC = 4;
  localparam int SF = 2;
  logic core_clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, send = 1'b0, skip = 1'b0;
  logic [3:0] bsel = 4'h0;
  logic [7:0] adr = 8'h00, code = 8'h00;
  logic [15:0] sel = 16'h0000, ptr = 16'h0000;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic [191:0] fill = '0;
  logic [255:0] frame, rsp;
  logic wb_ack_o, fv, rv, sync_mode, wd_check_on;
  logic [511:0] x;
  logic [63:0] y;
  logic [511:0] fq[$];
  logic [63:0] wq[$];
  int bad_count = 0, checks_done = 0, cycles = 0, nrsp = 0;
  int seed = 32'h2d91a46e;
  ////////////////////////////////////////
  fbas_cmd_core #(.EXEC_CYCLES(EXEC), .SYNC_FRAMES(SF)) fbas_cmd_core_i (.core_clk(core_clk), .rst_b(rst_b),
    .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_frame_valid(fv), .cmd_frame(frame), .rsp_frame(rsp),
    .rsp_frame_valid(rv), .sync_mode(sync_mode), .wd_check_on(wd_check_on));
  fbas_master_model fbas_master_model_i (.core_clk(core_clk), .rst_b(rst_b), .send(send), .skip_wd(skip),
    .code(code), .sel(sel), .ptr(ptr), .fill(fill), .cmd_frame_valid(fv), .cmd_frame(frame));
  // 250 MHz clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Compare one result and count it
  task automatic note(input string what, input logic [255:0] e, input logic [255:0] s);
    checks_done++;
    if (e !== s) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask
  // Verdict in one place, also reached by the timeout
  task automatic tally_and_finish();
    if (fq.size() + wq.size() != 0) begin
      bad_count++;
      $display("unexpected pending results: expected 0 seen %0d", fq.size() + wq.size());
    end
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Classic single cycle; holds the request until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w) wq.push_back({m, d & m});
    cyc <= 1'b1;
    stb <= 1'b1;
    bsel <= 4'hf;
    we <= w;
    adr <= a;
    dat <= d;
    // No local limit: only the bench timeout may end this wait
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  // Send one frame and note its expected response; busy answers check code and ready only
  task automatic fr(input logic [7:0] c, input logic [15:0] s, input logic k, input logic r,
                    input logic [3:0] al, input logic [191:0] l, input int gap);
    logic [255:0] e, m;
    logic [15:0] p;
    p = 16'($random(seed));
    m = r ? ~256'h0 : 256'h8000_00ff;
    m[15:8] = 8'h00;
    e = {l, c == 8'h05 ? p : 16'h0, (c == 8'h05 || c == 8'h06) ? s : 16'h0, r, 3'h0, al, 16'h0000, c};
    fq.push_back({m, e & m});
    send <= 1'b1;
    code <= c;
    sel <= s;
    ptr <= p;
    skip <= k;
    for (int i = 0; i < 6; i++) fill[32*i+:32] <= $random(seed);
    @(posedge core_clk);
    send <= 1'b0;
    skip <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask
  // New command: busy answer first, finished answer on the next frame with a fresh pointer
  task automatic cmd(input logic [7:0] c, input logic [15:0] s, input logic [3:0] al, input logic [191:0] l);
    fr(c, s, 1'b0, 1'b0, 4'h0, '0, EXEC + 3);
    fr(c, s, 1'b0, 1'b1, al, l, EXEC + 3);
  endtask
  // Master repeats sync start every other cycle until the last step reports ready
  task automatic sync_up();
    for (int i = 0; i <= SF; i++) fr(8'h0d, 16'h5a5a, 1'b0, i == SF, 4'h0, '0, 1);
  endtask
  // Result watcher: oldest note against each response or read answer
  always @(posedge core_clk) begin
    if (rst_b && rv === 1'b1) begin
      if (fq.size() == 0) note("response count", 256'h0, 256'h1);
      else begin
        x = fq.pop_front();
        note("response", x[255:0], rsp & x[511:256]);
        note("slave count", 256'(nrsp[7:0]), 256'(rsp[15:8]));
        nrsp++;
      end
    end
    if (rst_b && wb_ack_o === 1'b1 && !we && wq.size() != 0) begin
      y = wq.pop_front();
      note("bus read", 256'(y[31:0]), 256'(wb_dat_o & y[63:32]));
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("unexpected timeout: expected 0 seen %0d", cycles);
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    logic [15:0] a, b;
    a = 16'($random(seed)) | 16'h0100;
    b = 16'($random(seed)) | 16'h0100;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    wb(1'b1, FBAS_REG_CTRL, {a, 16'h0001}, '0);
    wb(1'b1, FBAS_REG_CTRL, {b, 16'h0001}, '0);
    repeat (4) @(posedge core_clk);
    wb(1'b0, FBAS_REG_STATUS, 32'h4, 32'h1f);
    wb(1'b0, 8'h40, 32'h0, '1);
    // Clock enable drops for three cycles mid-execution; the stall must fit inside the frame gap
    fork
      cmd(8'h05, 16'h0, 4'h0, {160'h0, a, b});
      begin
        repeat (3) @(posedge core_clk);
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
      end
    join
    cmd(8'h05, 16'h1, 4'h0, {160'h0, a, b});
    cmd(8'h05, 16'h2, 4'h9, '0);
    cmd(8'h06, 16'h0, 4'h0, '0);
    cmd(8'h05, 16'h0, 4'h0, '0);
    cmd(8'h05, 16'h1, 4'h0, {160'h0, a, b});
    cmd(8'h06, 16'h1, 4'h0, '0);
    cmd(8'h05, 16'h1, 4'h0, '0);
    cmd(8'h06, 16'h3, 4'h9, '0);
    sync_up();
    wb(1'b0, FBAS_REG_STATUS, 32'h7, 32'h1f);
    fr(8'h7e, 16'h0, 1'b1, 1'b1, 4'h0, '0, EXEC + 3);
    wb(1'b0, FBAS_REG_STATUS, 32'h4, 32'h1f);
    cmd(8'h05, 16'h0, 4'h0, {176'h0, FBAS_WD_FAULT_CODE});
    cmd(8'h06, 16'h0, 4'h0, '0);
    sync_up();
    wb(1'b0, FBAS_REG_STATUS, 32'h7, 32'h1f);
    repeat (4) @(posedge core_clk);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
